// [rtl/rmc_mode_ctrl.sv]
// Mode select, busy indicator and address filter of the serial radio module.
// Assumes UART and radio logic on ref_clk; mode pins arrive asynchronously.
//
// Function
// - All-ones/zeros sender address reaches every listener
// - All-ones/zeros own address accepts any target
// - Indicator low at once through self-check
// - Indicator rises, pin-selected mode starts
// - 1000-byte buffer; high means drained
// - Low while buffer not handed to radio
// - Low before and during serial output
// - Low if any busy condition holds
// - Pins ignored while busy
// - Change during busy, except to sleep: new mode 2ms later
// - Reload after sleep or reset, indicator low
// - Pins decode to four modes
// - Normal: serial and radio, air config
// - Wake-on-air transmit or receive
// - Configuration: register access over serial
// - Idle change starts after 1ms
// - Finish pending transfer before switching
// - Sleep entered after pending data, 1ms
// - Idle or sleep change completes within 1ms; held-off change 2ms
//
// The Avalon-MM slave port and the register offsets were left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module rmc_mode_ctrl
	import rmc_pkg::*;
#(
	parameter int P_SWITCH_CYC   = SWITCH_CYC,
	parameter int P_SETTLE_CYC   = SETTLE_CYC,
	parameter int P_RELOAD_CYC   = RELOAD_CYC,
	parameter int P_TX_BUF_BYTES = TX_BUF_BYTES
)
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                srst,
	// Mode select pins
	input  wire rmc_mode_pins_t      mode_pins,
	// Host serial bytes into the transmit buffer
	input  wire logic                host_byte_valid,
	output var  logic                host_byte_ready,
	input  wire logic                radio_byte_take,
	// Received data towards the serial output
	input  wire logic                rx_out_pending,
	output var  logic                rx_out_go,
	// Radio receive filter
	input  wire logic                rx_pkt_valid,
	input  wire rmc_pkt_hdr_t        rx_pkt_hdr,
	output var  logic                rx_pkt_accept,
	// Radio transmit header
	output var  rmc_pkt_hdr_t        tx_pkt_hdr,
	output var  logic                tx_broadcast,
	// Mode state
	output var  logic                ready_ind,
	output var  logic [1:0]          active_mode,
	output var  logic                radio_enable,
	output var  logic                wor_enable,
	output var  logic                ota_cfg_enable,
	output var  logic                cfg_access_enable,
	output var  logic                sleep_enable,
	// Avalon-MM slave
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [3:0]          avs_byteenable,
	input  wire logic [31:0]         avs_writedata,
	output var  logic [31:0]         avs_readdata,
	output var  logic                avs_waitrequest
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (P_SWITCH_CYC < 1 || P_SETTLE_CYC < 1 || P_RELOAD_CYC < 1 ||
		P_SWITCH_CYC >= (1 << TMR_W) || P_SETTLE_CYC >= (1 << TMR_W) ||
		P_RELOAD_CYC >= (1 << TMR_W))
	begin : g_bad_tmr
		$error("timer counts out of range");
	end
	if (P_TX_BUF_BYTES < 1 || P_TX_BUF_BYTES >= (1 << TX_CNT_W))
	begin : g_bad_buf
		$error("buffer size out of range");
	end

	localparam logic [TMR_W-1:0]    LD_SWITCH = TMR_W'(P_SWITCH_CYC - 1);
	localparam logic [TMR_W-1:0]    LD_SETTLE = TMR_W'(P_SETTLE_CYC - 1);
	localparam logic [TMR_W-1:0]    LD_RELOAD = TMR_W'(P_RELOAD_CYC - 1);
	localparam logic [TX_CNT_W-1:0] BUF_MAX   = TX_CNT_W'(P_TX_BUF_BYTES);

	function automatic logic is_wild(input logic [15:0] a);
		is_wild = (a == ADDR_ALL_ONES) || (a == ADDR_ALL_ZEROS);
	endfunction

	// ****************************************
	// Pin synchronisation
	// ****************************************
	rmc_mode_pins_t pins_s;

	rmc_sync2 #(
		.W (2)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.srst    (srst),
		.din     (mode_pins),
		.dout    (pins_s)
	);

	// ****************************************
	// Mode state machine
	// ****************************************
	rmc_state_t            state_ff;
	logic [TMR_W-1:0]      tmr_ff;
	logic [1:0]            mode_ff;
	logic [1:0]            tgt_ff;
	logic                  rdy_prev_ff;
	logic [TX_CNT_W-1:0]   tx_cnt_ff;
	logic [15:0]           own_addr_ff;
	logic [7:0]            chan_ff;
	logic                  busy;
	logic                  just_rose;
	logic                  pins_differ;

	assign busy        = (state_ff == ST_RELOAD) || (tx_cnt_ff != '0) ||
		rx_out_pending;
	assign just_rose   = ready_ind && !rdy_prev_ff;
	assign pins_differ = pins_s != mode_ff;

	// Indicator is the inverse of the OR of all busy causes
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ready_ind   <= 1'b0;
			rdy_prev_ff <= 1'b0;
		end
		else
		begin
			ready_ind   <= !busy;
			rdy_prev_ff <= ready_ind;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_ff <= ST_RELOAD;
			tmr_ff   <= LD_RELOAD;
			mode_ff  <= MODE_NORMAL;
			tgt_ff   <= MODE_NORMAL;
		end
		else
		begin
			case (state_ff)
				ST_RELOAD:
				begin
					if (tmr_ff == '0)
					begin
						mode_ff  <= pins_s;
						state_ff <= ST_RUN;
					end
					else
						tmr_ff <= tmr_ff - 1'b1;
				end
				ST_RUN:
				begin
					// Pins looked at only while the indicator is high
					if (ready_ind && pins_differ)
					begin
						tgt_ff   <= pins_s;
						state_ff <= ST_SWITCH;
						// A change held off by busy, unless to sleep, waits out the settle time
						if (just_rose && pins_s != MODE_SLEEP)
							tmr_ff <= LD_SETTLE;
						else
							tmr_ff <= LD_SWITCH;
					end
				end
				ST_SWITCH:
				begin
					if (ready_ind && pins_differ && pins_s != tgt_ff)
					begin
						tgt_ff <= pins_s;
						tmr_ff <= LD_SWITCH;
					end
					else if (tmr_ff == '0)
					begin
						mode_ff <= tgt_ff;
						if (mode_ff == MODE_SLEEP)
						begin
							state_ff <= ST_RELOAD;
							tmr_ff   <= LD_RELOAD;
						end
						else
							state_ff <= ST_RUN;
					end
					else
						tmr_ff <= tmr_ff - 1'b1;
				end
				default:
				begin
					state_ff <= ST_RELOAD;
					tmr_ff   <= LD_RELOAD;
				end
			endcase
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			active_mode       <= MODE_NORMAL;
			radio_enable      <= 1'b0;
			wor_enable        <= 1'b0;
			ota_cfg_enable    <= 1'b0;
			cfg_access_enable <= 1'b0;
			sleep_enable      <= 1'b0;
		end
		else
		begin
			active_mode       <= mode_ff;
			radio_enable      <= state_ff != ST_RELOAD &&
				(mode_ff == MODE_NORMAL || mode_ff == MODE_WOR);
			wor_enable        <= state_ff != ST_RELOAD && mode_ff == MODE_WOR;
			ota_cfg_enable    <= state_ff != ST_RELOAD && mode_ff == MODE_NORMAL;
			cfg_access_enable <= state_ff != ST_RELOAD && mode_ff == MODE_CFG;
			sleep_enable      <= state_ff != ST_RELOAD && mode_ff == MODE_SLEEP;
		end
	end

	// ****************************************
	// Transmit buffer occupancy
	// ****************************************
	logic push;
	logic pop;

	assign push = host_byte_valid && host_byte_ready;
	assign pop  = radio_byte_take && (tx_cnt_ff != '0);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			tx_cnt_ff <= '0;
		else if (push && !pop)
			tx_cnt_ff <= tx_cnt_ff + 1'b1;
		else if (pop && !push)
			tx_cnt_ff <= tx_cnt_ff - 1'b1;
	end

	// New bytes only in a running data mode; none after the first cycle of a switch
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			host_byte_ready <= 1'b0;
		else
			host_byte_ready <= state_ff == ST_RUN &&
				(mode_ff == MODE_NORMAL || mode_ff == MODE_WOR) &&
				(tx_cnt_ff + TX_CNT_W'(push)) < BUF_MAX;
	end

	// Serial output waits one cycle for the indicator to fall first
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rx_out_go <= 1'b0;
		else
			rx_out_go <= rx_out_pending && !ready_ind;
	end

	// ****************************************
	// Address filter and transmit header
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rx_pkt_accept <= 1'b0;
			tx_pkt_hdr    <= '0;
			tx_broadcast  <= 1'b0;
		end
		else
		begin
			rx_pkt_accept <= rx_pkt_valid && radio_enable && rx_pkt_hdr.chan == chan_ff &&
				(rx_pkt_hdr.dst == own_addr_ff || is_wild(rx_pkt_hdr.dst) ||
				is_wild(own_addr_ff));
			tx_pkt_hdr.dst  <= own_addr_ff;
			tx_pkt_hdr.chan <= chan_ff;
			tx_broadcast    <= is_wild(own_addr_ff);
		end
	end

	// ****************************************
	// Register slave
	// ****************************************
	logic req;
	logic wr_take;

	assign req     = avs_read || avs_write;
	assign wr_take = avs_write && !avs_waitrequest;

	// One wait cycle, then a single acknowledge cycle
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(req && avs_waitrequest);
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			avs_readdata <= '0;
		else if (avs_read && avs_waitrequest)
		begin
			avs_readdata <= '0;
			case (avs_address)
				REG_OWN_ADDR: avs_readdata[15:0] <= own_addr_ff;
				REG_CHANNEL:  avs_readdata[7:0]  <= chan_ff;
				REG_STATUS:
				begin
					avs_readdata[ST_READY_BIT]                     <= ready_ind;
					avs_readdata[ST_MODE_LSB +: 2]                 <= mode_ff;
					avs_readdata[ST_SWITCH_BIT]                    <= state_ff == ST_SWITCH;
					avs_readdata[ST_RELOAD_BIT]                    <= state_ff == ST_RELOAD;
					avs_readdata[ST_TXCNT_LSB +: TX_CNT_W]         <= tx_cnt_ff;
				end
				default: avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			own_addr_ff <= OWN_ADDR_RST;
			chan_ff     <= CHANNEL_RST;
		end
		else if (wr_take)
		begin
			if (avs_address == REG_OWN_ADDR)
			begin
				if (avs_byteenable[0])
					own_addr_ff[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					own_addr_ff[15:8] <= avs_writedata[15:8];
			end
			if (avs_address == REG_CHANNEL && avs_byteenable[0])
				chan_ff <= avs_writedata[7:0];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	sequence s_switch_end;
		state_ff == ST_SWITCH && tmr_ff == '0 &&
			!(ready_ind && pins_differ && pins_s != tgt_ff);
	endsequence

	sequence s_enter_switch;
		state_ff == ST_RUN && ready_ind && pins_differ;
	endsequence

	AST_RESET_LOW: assert property (disable iff (1'b0) srst |=> !ready_ind)
		else $error("indicator not low after reset");
	AST_BUF_LOW: assert property (tx_cnt_ff != '0 |=> !ready_ind)
		else $error("indicator high with buffered bytes");
	AST_RX_LOW: assert property (rx_out_go |-> !ready_ind && $past(!ready_ind))
		else $error("serial output without low indicator");
	AST_NO_EVAL: assert property (state_ff == ST_RUN && !ready_ind |=> state_ff != ST_SWITCH)
		else $error("pins evaluated while busy");
	AST_SETTLE: assert property (s_enter_switch and just_rose && pins_s != MODE_SLEEP
		|=> tmr_ff == LD_SETTLE)
		else $error("settle time not loaded");
	AST_IDLE_SW: assert property (s_enter_switch and !just_rose |=> tmr_ff == LD_SWITCH)
		else $error("switch time not loaded");
	AST_APPLY: assert property (s_switch_end |=> mode_ff == $past(tgt_ff))
		else $error("target mode not applied");
	AST_RELOAD: assert property (s_switch_end and mode_ff == MODE_SLEEP
		|=> state_ff == ST_RELOAD ##1 !ready_ind)
		else $error("no reload after sleep");
	AST_MONITOR: assert property (rx_pkt_valid && radio_enable && rx_pkt_hdr.chan == chan_ff &&
		is_wild(own_addr_ff) |=> rx_pkt_accept)
		else $error("monitor packet dropped");
	AST_BCAST: assert property (rx_pkt_valid && radio_enable && rx_pkt_hdr.chan == chan_ff &&
		is_wild(rx_pkt_hdr.dst) |=> rx_pkt_accept)
		else $error("broadcast packet dropped");
	AST_BUF_CAP: assert property (tx_cnt_ff <= BUF_MAX)
		else $error("buffer overflow");
	AST_CFG: assert property (cfg_access_enable |-> active_mode == MODE_CFG)
		else $error("register access outside config mode");

endmodule

`default_nettype wire

// [rtl/rmc_pkg.sv]
// Constants and carrier types for the radio module mode and busy control.
// Assumes a single 25 MHz core clock shared by every user of this package.

package rmc_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_FREQ_MHZ = 25;
	localparam int T_SWITCH_US  = 1000;
	localparam int T_SETTLE_US  = 2000;
	localparam int T_RELOAD_US  = 200;
	localparam int SWITCH_CYC   = T_SWITCH_US * CLK_FREQ_MHZ;
	localparam int SETTLE_CYC   = T_SETTLE_US * CLK_FREQ_MHZ;
	localparam int RELOAD_CYC   = T_RELOAD_US * CLK_FREQ_MHZ;
	localparam int TMR_W        = 17;

	// ****************************************
	// Buffer and addressing
	// ****************************************
	localparam int          TX_BUF_BYTES   = 1000;
	localparam int          TX_CNT_W       = 10;
	localparam logic [15:0] ADDR_ALL_ONES  = 16'hffff;
	localparam logic [15:0] ADDR_ALL_ZEROS = 16'h0000;

	// ****************************************
	// Operating modes, high:low select pins
	// ****************************************
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_WOR    = 2'h1;
	localparam logic [1:0] MODE_CFG    = 2'h2;
	localparam logic [1:0] MODE_SLEEP  = 2'h3;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [3:0]  REG_OWN_ADDR  = 4'h0;
	localparam logic [3:0]  REG_CHANNEL   = 4'h4;
	localparam logic [3:0]  REG_STATUS    = 4'h8;
	localparam logic [15:0] OWN_ADDR_RST  = 16'h0001;
	localparam logic [7:0]  CHANNEL_RST   = 8'h00;
	localparam int          ST_READY_BIT  = 0;
	localparam int          ST_MODE_LSB   = 1;
	localparam int          ST_SWITCH_BIT = 3;
	localparam int          ST_RELOAD_BIT = 4;
	localparam int          ST_TXCNT_LSB  = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
	} rmc_mode_pins_t;

	typedef struct packed {
		logic [15:0] dst;
		logic [7:0]  chan;
	} rmc_pkt_hdr_t;

	typedef enum logic [1:0] {
		ST_RELOAD,
		ST_RUN,
		ST_SWITCH
	} rmc_state_t;

endpackage

// [rtl/rmc_sync2.sv]
// Two-flop synchroniser for pin levels.
// Assumes the inputs are quasi-static levels such as mode select straps.

`timescale 1ns/10ps
`default_nettype none

module rmc_sync2
	import rmc_pkg::*;
#(
	parameter int W = 2
)
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         srst,
	// Levels
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			meta_ff <= '0;
			dout    <= '0;
		end
		else
		begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end

endmodule

`default_nettype wire

// [testbench/rmc_radio_model.sv]
// Radio side model: drains transmit bytes and plays received serial output.
// Assumes ref_clk is the core clock of the mode controller.
`timescale 1ns/10ps
`default_nettype none

module rmc_radio_model
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// Bench control
	input  wire logic drain_en,
	input  wire logic rx_start,
	// Towards the controller
	output var  logic radio_byte_take,
	output var  logic rx_out_pending
);
	logic [1:0] gap_ff;
	logic [3:0] rx_cnt_ff;

	// Slow radio, one byte every third cycle, keeps the buffer busy a while
	always_ff @(posedge ref_clk)
	begin
		if (srst || !drain_en)
		begin
			gap_ff          <= 2'h0;
			radio_byte_take <= 1'b0;
		end
		else
		begin
			gap_ff          <= (gap_ff == 2'h2) ? 2'h0 : gap_ff + 2'h1;
			radio_byte_take <= (gap_ff == 2'h2);
		end
	end

	// Received frame pending for a fixed serial length
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rx_cnt_ff <= 4'h0;
		else if (rx_start)
			rx_cnt_ff <= 4'hc;
		else if (rx_cnt_ff != 4'h0)
			rx_cnt_ff <= rx_cnt_ff - 4'h1;
	end

	assign rx_out_pending = (rx_cnt_ff != 4'h0);

endmodule
`default_nettype wire

// [testbench/rmc_mode_ctrl_tb.sv]
// Self-checking bench for the mode and busy controller.
// Assumes the design's own assertions; shortened counts via parameters.
`timescale 1ns/10ps
`default_nettype none

module rmc_mode_ctrl_tb
	import rmc_pkg::*;
();
	localparam int SW = 20;
	localparam int ST = 40;
	logic           ref_clk, srst, host_byte_valid, host_byte_ready, radio_byte_take;
	logic           rx_out_pending, rx_out_go, rx_pkt_valid, rx_pkt_accept, tx_broadcast;
	logic           ready_ind, radio_enable, wor_enable, ota_cfg_enable, cfg_access_enable;
	logic           sleep_enable, avs_read, avs_write, avs_waitrequest, drain_en, rx_start, vd;
	rmc_mode_pins_t mode_pins;
	rmc_pkt_hdr_t   rx_pkt_hdr, tx_pkt_hdr;
	logic [1:0]     active_mode, mode_d, ms[4];
	logic [3:0]     avs_address, avs_byteenable;
	logic [31:0]    avs_writedata, avs_readdata, r;
	logic [31:0]    rd_q[$];
	logic [1:0]     md_q[$];
	logic           acc_q[$];
	integer         mismatches = 0, cmp_count = 0, seed = 84025, n;

	rmc_mode_ctrl #(.P_SWITCH_CYC(SW), .P_SETTLE_CYC(ST), .P_RELOAD_CYC(10),
		.P_TX_BUF_BYTES(8)) DUT (.ref_clk, .srst, .mode_pins, .host_byte_valid,
		.host_byte_ready, .radio_byte_take, .rx_out_pending, .rx_out_go, .rx_pkt_valid,
		.rx_pkt_hdr, .rx_pkt_accept, .tx_pkt_hdr, .tx_broadcast, .ready_ind, .active_mode,
		.radio_enable, .wor_enable, .ota_cfg_enable, .cfg_access_enable, .sleep_enable,
		.avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
		.avs_readdata, .avs_waitrequest);

	rmc_radio_model radio (.ref_clk, .srst, .drain_en, .rx_start, .radio_byte_take,
		.rx_out_pending);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic wrap_up;
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tmo;
		mismatches++;
		wrap_up();
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
		input logic [31:0] d);
		integer k;
		k = 0;
		@(posedge ref_clk);
		avs_address    <= a;
		avs_read       <= !wr;
		avs_write      <= wr;
		avs_byteenable <= be;
		avs_writedata  <= d;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 20);
		if (k >= 20)
			tmo();
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 4'hf, 32'h0);
	endtask

	task automatic pkt(input logic [15:0] dst, input logic [7:0] ch, input logic e);
		acc_q.push_back(e);
		@(posedge ref_clk);
		rx_pkt_valid <= 1'b1;
		rx_pkt_hdr   <= rmc_pkt_hdr_t'({dst, ch});
		@(posedge ref_clk);
		rx_pkt_valid <= 1'b0;
	endtask

	task automatic wait_rdy(input logic v);
		integer k;
		k = 0;
		while (ready_ind !== v && k < 300)
		begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 300)
			tmo();
	endtask

	// Cycles from the pin change until the new mode shows
	task automatic set_mode(input logic [1:0] m, output integer k);
		md_q.push_back(m);
		@(posedge ref_clk);
		mode_pins <= rmc_mode_pins_t'(m);
		k = 0;
		while (active_mode !== m && k < 300)
		begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 300)
			tmo();
	endtask

	function automatic logic [4:0] en_of(input logic [1:0] m);
		case (m)
			MODE_NORMAL: en_of = 5'h14;
			MODE_WOR:    en_of = 5'h18;
			MODE_CFG:    en_of = 5'h02;
			default:     en_of = 5'h01;
		endcase
	endfunction

	// ****************************************
	// Output watcher
	// ****************************************
	always @(posedge ref_clk)
	begin
		vd     <= rx_pkt_valid;
		mode_d <= active_mode;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk("avs_readdata", avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hx);
		if (vd === 1'b1)
			chk("rx_pkt_accept", rx_pkt_accept, acc_q.size() ? acc_q.pop_front() : 1'bx);
		if (srst === 1'b0 && active_mode !== mode_d)
			chk("active_mode", active_mode, md_q.size() ? md_q.pop_front() : 2'bx);
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (100000) @(posedge ref_clk);
		tmo();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		srst = 1'b1;
		mode_pins = rmc_mode_pins_t'(MODE_NORMAL);
		{host_byte_valid, rx_pkt_valid, avs_read, avs_write, drain_en, rx_start} = 6'h00;
		rx_pkt_hdr = '0;
		avs_address = 4'h0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		ms = '{MODE_WOR, MODE_CFG, MODE_SLEEP, MODE_NORMAL};
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("ready_ind", ready_ind, 1'b0);
		wait_rdy(1'b1);
		chk("active_mode", active_mode, MODE_NORMAL);
		rd(REG_OWN_ADDR, 32'h1);
		rd(REG_CHANNEL, 32'h0);
		rd(4'hc, 32'h0);
		rd(REG_STATUS, 32'h1);
		bus(1'b1, 4'hc, 4'hf, 32'hffffffff);
		bus(1'b1, REG_OWN_ADDR, 4'h1, 32'habcd);
		rd(REG_OWN_ADDR, 32'hcd);
		bus(1'b1, REG_OWN_ADDR, 4'hf, 32'hffff);
		bus(1'b1, REG_CHANNEL, 4'hf, 32'h4);
		// Header flops trail the register write by one cycle
		repeat (2) @(posedge ref_clk);
		chk("tx_broadcast", tx_broadcast, 1'b1);
		chk("tx_pkt_hdr", tx_pkt_hdr, {16'hffff, 8'h04});
		r = $random(seed);
		pkt(r[15:0], 8'h04, 1'b1);
		pkt(r[15:0], 8'h05, 1'b0);
		bus(1'b1, REG_OWN_ADDR, 4'hf, 32'h0);
		pkt(r[31:16], 8'h04, 1'b1);
		bus(1'b1, REG_OWN_ADDR, 4'hf, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("tx_broadcast", tx_broadcast, 1'b0);
		pkt(16'h0001, 8'h04, 1'b1);
		pkt((r[15:0] & 16'h7ff0) | 16'h0100, 8'h04, 1'b0);
		pkt(16'hffff, 8'h04, 1'b1);
		pkt(16'h0000, 8'h04, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			set_mode(ms[i], n);
			chk("switch_cycles", n >= SW && n <= SW + 8, 1'b1);
			if (ms[i] == MODE_NORMAL)
			begin
				@(posedge ref_clk);
				chk("ready_ind", ready_ind, 1'b0);
				wait_rdy(1'b1);
			end
			@(posedge ref_clk);
			chk("enables", {radio_enable, wor_enable, ota_cfg_enable, cfg_access_enable,
				sleep_enable}, en_of(ms[i]));
		end
		// Radio stalled so the buffer must refuse at its size
		@(posedge ref_clk);
		host_byte_valid <= 1'b1;
		n = 0;
		repeat (30)
		begin
			@(posedge ref_clk);
			if (host_byte_ready === 1'b1)
				n++;
		end
		host_byte_valid <= 1'b0;
		chk("bytes_taken", n, 8);
		chk("ready_ind", ready_ind, 1'b0);
		md_q.push_back(MODE_CFG);
		mode_pins <= rmc_mode_pins_t'(MODE_CFG);
		repeat (10) @(posedge ref_clk);
		chk("active_mode", active_mode, MODE_NORMAL);
		drain_en <= 1'b1;
		wait_rdy(1'b1);
		n = 0;
		while (active_mode !== MODE_CFG && n < 300)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 300)
			tmo();
		chk("settle_cycles", n >= ST && n <= ST + 8, 1'b1);
		set_mode(MODE_NORMAL, n);
		@(posedge ref_clk);
		rx_start <= 1'b1;
		@(posedge ref_clk);
		rx_start <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("ready_ind", ready_ind, 1'b0);
		chk("rx_out_go", rx_out_go, 1'b1);
		wait_rdy(1'b1);
		// Sleep chosen with bytes still pending
		host_byte_valid <= 1'b1;
		repeat (3) @(posedge ref_clk);
		host_byte_valid <= 1'b0;
		set_mode(MODE_SLEEP, n);
		chk("sleep_cycles", n >= SW && n <= SW + 24, 1'b1);
		set_mode(MODE_NORMAL, n);
		wait_rdy(1'b1);
		wrap_up();
	end

endmodule
`default_nettype wire
